// *** hw/srct_seq.sv ***
// reset sequencer, config-port arbiter and equalizer tuner for one octal
//
// The address map and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "srct_map.svh"
module srct_seq
  import srct_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        tx_reset_complete,
  input  wire logic        rx_reset_complete,
  input  wire logic        tx_pll_locked,
  input  wire logic        rx_pll_locked,
  input  wire srct_cfg_rsp_t cfg_rsp,
  output srct_cfg_req_t    cfg_req,
  output logic      [7:0]  tx_serializer_enable,
  output logic      [7:0]  rx_deserializer_enable,
  output logic             pll_recalibrate,
  output logic             tx_side_reset,
  output logic             rx_side_reset,
  output logic             rx_fabric_if_reset,
  output logic             fsm_done,
  output logic             config_port_busy
);

  // ****************************************************************
  // state
  // ****************************************************************
  srct_st_t st;
  srct_st_t next_st;
  logic     xfer_done;
  logic     tune_all_done;
  logic     addr_ok;

  function automatic logic [7:0] lane_mask_f(input logic [7:0] want,
                                             input logic [7:0] dis,
                                             input logic [7:0] en);
    lane_mask_f = want & ~dis & en;
  endfunction

  function automatic logic [7:0] lane_dec_f(input logic [2:0] sel);
    lane_dec_f = 8'h01 << sel;
  endfunction

  assign pready = 1'b1;
  assign addr_ok = (paddr == `SRCT_OFF_CTRL) || (paddr == `SRCT_OFF_TUNE) ||
                   (paddr == `SRCT_OFF_ADDR) || (paddr == `SRCT_OFF_AUX) ||
                   (paddr == `SRCT_OFF_STATUS);
  assign pslverr = psel && penable && !addr_ok;
  assign prdata  = st.prdata;
  assign cfg_req = st.req;
  assign tx_serializer_enable   = st.out.tx_en;
  assign rx_deserializer_enable = st.out.rx_en;
  assign pll_recalibrate        = st.out.recal;
  assign tx_side_reset          = st.out.tx_rst;
  assign rx_side_reset          = st.out.rx_rst;
  assign rx_fabric_if_reset     = st.out.fab_rst;
  assign fsm_done               = st.out.done;
  assign config_port_busy       = st.out.busy;

  always_comb begin
    next_st = st;
    next_st.req.rd = 1'b0;
    next_st.req.wr = 1'b0;
    xfer_done = 1'b0;
    tune_all_done = ((cfg_rsp.rdata[7:0] & st.tune_mask) == st.tune_mask);

    // ****************************************************************
    // config port: one owner, one transaction at a time
    // ****************************************************************
    if (st.own == OWN_NONE) begin
      // full rx reset first, then analog reset, then rate change
      if (st.pend[0]) begin
        next_st.own = OWN_FULL;
      end else if (st.pend[1]) begin
        next_st.own = OWN_ANA;
      end else if (st.pend[2]) begin
        next_st.own = OWN_RATE;
      end else if (st.fsm == S_TWR || st.fsm == S_TRD) begin
        next_st.own = OWN_TUNE;
      end
    end else if (!st.issued) begin
      next_st.issued = 1'b1;
      if (st.own == OWN_TUNE) begin
        next_st.req.rd = (st.fsm == S_TRD);
        next_st.req.wr = (st.fsm == S_TWR);
        next_st.req.addr  = (st.fsm == S_TRD) ? st.stat_addr : st.mode_addr;
        next_st.req.wdata = {4'h0, st.mode, st.tune_mask};
      end else begin
        // each sequencer writes its own word above the base address
        next_st.req.wr    = 1'b1;
        next_st.req.addr  = st.aux_addr + {13'h0000, st.own};
        next_st.req.wdata = st.aux_data;
      end
    end else if (cfg_rsp.ready) begin
      // port stays held until the octal answers
      next_st.issued = 1'b0;
      next_st.own    = OWN_NONE;
      xfer_done      = (st.own == OWN_TUNE);
      unique case (st.own)
        OWN_FULL: next_st.pend[0] = 1'b0;
        OWN_ANA:  next_st.pend[1] = 1'b0;
        OWN_RATE: next_st.pend[2] = 1'b0;
        default:  next_st.pend = st.pend;
      endcase
    end

    // ****************************************************************
    // reset and tuning sequence
    // ****************************************************************
    unique case (st.fsm)
      S_INIT: begin
        next_st.fsm = S_PLL;
        next_st.cnt = `SRCT_HOLD_CYC;
      end
      S_PLL: begin
        next_st.cnt = st.cnt - 8'h01;
        if (st.cnt == 8'h01) begin
          next_st.fsm = S_LOCK;
        end
      end
      S_LOCK: begin
        if (tx_pll_locked && rx_pll_locked) begin
          if (st.pll_only) begin
            next_st.fsm      = S_DONE;
            next_st.pll_only = 1'b0;
          end else begin
            next_st.fsm = S_RST;
            next_st.cnt = `SRCT_HOLD_CYC;
          end
        end
      end
      S_RST: begin
        next_st.cnt = st.cnt - 8'h01;
        if (st.cnt == 8'h01) begin
          next_st.fsm = S_RDONE;
        end
      end
      S_RDONE: begin
        if ((st.rx_only || tx_reset_complete) && rx_reset_complete) begin
          next_st.rx_only   = 1'b0;
          next_st.tuned     = 8'h00;
          next_st.tune_mask = lane_mask_f(st.tune_mask, st.dis_mask, st.lane_en);
          if (lane_mask_f(st.tune_mask, st.dis_mask, st.lane_en) == 8'h00) begin
            next_st.fsm = S_DONE;
          end else begin
            next_st.fsm = S_TWR;
          end
        end
      end
      S_TWR: begin
        if (xfer_done) begin
          next_st.fsm = S_TRD;
        end
      end
      S_TRD: begin
        // keep polling until every selected lane reports finished
        if (xfer_done) begin
          next_st.tuned = cfg_rsp.rdata[7:0] & st.tune_mask;
          if (tune_all_done) begin
            next_st.fsm = S_DONE;
          end
        end
      end
      S_DONE: begin
        if (st.user_req[`SRCT_CTRL_PLLONLY]) begin
          next_st.user_req[`SRCT_CTRL_PLLONLY] = 1'b0;
          next_st.pll_only = 1'b1;
          next_st.fsm      = S_PLL;
          next_st.cnt      = `SRCT_HOLD_CYC;
        end else if (st.user_req[`SRCT_CTRL_RXRETUNE]) begin
          next_st.user_req[`SRCT_CTRL_RXRETUNE] = 1'b0;
          next_st.rx_only   = 1'b1;
          next_st.tune_mask = 8'hff;
          next_st.fsm       = S_RST;
          next_st.cnt       = `SRCT_HOLD_CYC;
        end else if (st.user_req[`SRCT_CTRL_RETUNE]) begin
          next_st.user_req[`SRCT_CTRL_RETUNE] = 1'b0;
          next_st.tuned = 8'h00;
          // only the selected lane is retuned, no reset is repeated
          next_st.tune_mask = lane_mask_f(lane_dec_f(st.lane_sel),
                                          st.dis_mask, st.lane_en);
          if (lane_mask_f(lane_dec_f(st.lane_sel), st.dis_mask, st.lane_en) == 8'h00) begin
            next_st.fsm = S_DONE;
          end else begin
            next_st.fsm = S_TWR;
          end
        end
      end
    endcase

    // ****************************************************************
    // apb slave; writes come last so a new request beats a clear
    // ****************************************************************
    if (psel && !penable) begin
      unique case (paddr)
        `SRCT_OFF_CTRL:   next_st.prdata = {21'h0, st.lane_sel, 2'h0, st.pend, st.user_req};
        `SRCT_OFF_TUNE:   next_st.prdata = {8'h0, st.lane_en, 4'h0, st.mode, st.dis_mask};
        `SRCT_OFF_ADDR:   next_st.prdata = {st.mode_addr, st.stat_addr};
        `SRCT_OFF_AUX:    next_st.prdata = {st.aux_data, st.aux_addr};
        `SRCT_OFF_STATUS: next_st.prdata = {8'h0, st.tuned, 8'h0, st.own,
                                            st.fsm, st.out.busy, st.out.done};
        default:          next_st.prdata = 32'h0000_0000;
      endcase
    end
    if (psel && penable && pwrite) begin
      unique case (paddr)
        `SRCT_OFF_CTRL: begin
          next_st.user_req = next_st.user_req | pwdata[2:0];
          next_st.pend     = next_st.pend | pwdata[`SRCT_CTRL_SEQ_LSB +: 3];
          next_st.lane_sel = pwdata[`SRCT_CTRL_LANE_LSB +: 3];
        end
        `SRCT_OFF_TUNE: begin
          next_st.dis_mask = pwdata[7:0];
          next_st.mode     = pwdata[`SRCT_TUNE_MODE_LSB +: 4];
          next_st.lane_en  = pwdata[`SRCT_TUNE_EN_LSB +: 8];
        end
        `SRCT_OFF_ADDR: begin
          next_st.stat_addr = pwdata[15:0];
          next_st.mode_addr = pwdata[31:16];
        end
        `SRCT_OFF_AUX: begin
          next_st.aux_addr = pwdata[15:0];
          next_st.aux_data = pwdata[31:16];
        end
        default: next_st.aux_addr = next_st.aux_addr;
      endcase
    end

    // ****************************************************************
    // registered outputs follow the next state
    // ****************************************************************
    next_st.out.tx_en = (next_st.fsm == S_INIT) ? 8'h00 : next_st.lane_en;
    next_st.out.rx_en = (next_st.fsm == S_INIT) ? 8'h00 : next_st.lane_en;
    next_st.out.recal = (next_st.fsm == S_PLL) &&
                        ((|next_st.out.tx_en) || (|next_st.out.rx_en));
    next_st.out.tx_rst = !next_st.pll_only &&
                         ((next_st.fsm inside {S_INIT, S_PLL, S_LOCK}) ||
                          (next_st.fsm == S_RST && !next_st.rx_only));
    next_st.out.rx_rst = !next_st.pll_only &&
                         (next_st.fsm inside {S_INIT, S_PLL, S_LOCK, S_RST});
    next_st.out.fab_rst = next_st.out.rx_rst;
    next_st.out.done    = (next_st.fsm == S_DONE);
    // busy also covers requests still waiting for the port
    next_st.out.busy = (next_st.own != OWN_NONE) || (|next_st.pend) ||
                       (next_st.fsm inside {S_TWR, S_TRD});
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st           <= '0;
      st.fsm       <= S_INIT;
      st.own       <= OWN_NONE;
      st.tune_mask <= 8'hff;
      st.lane_en   <= `SRCT_LANE_EN_RST;
      st.out       <= '{tx_en: 8'h00, rx_en: 8'h00, recal: 1'b0, tx_rst: 1'b1,
                        rx_rst: 1'b1, fab_rst: 1'b1, done: 1'b0, busy: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_EXCL_HOLD: assert property ((st.own != OWN_NONE && st.issued && !cfg_rsp.ready)
                    |=> st.own == $past(st.own))
    else $error("config port owner changed mid transaction");
  AST_BUSY_OWNED: assert property ((st.own != OWN_NONE) |-> config_port_busy)
    else $error("busy low while a sequencer owns the port");
  AST_FULL_FIRST: assert property ((st.own == OWN_NONE && st.pend[0])
                    |=> st.own == OWN_FULL)
    else $error("full rx reset sequencer not granted first");
  AST_FAB_RST: assert property ((st.fsm == S_RST) |-> rx_fabric_if_reset && rx_side_reset)
    else $error("rx resets missing during reset phase");
  AST_TX_RST: assert property ((st.fsm == S_PLL && !st.pll_only) |-> tx_side_reset)
    else $error("tx reset missing during pll phase");
  AST_RECAL: assert property (pll_recalibrate
                |-> (|tx_serializer_enable) || (|rx_deserializer_enable))
    else $error("recalibration without any enable");
  AST_DONE_WAIT: assert property ((st.fsm == S_RDONE && !rx_reset_complete) |=> !fsm_done)
    else $error("done before rx left reset");
  AST_ONE_TXN: assert property ((cfg_req.rd || cfg_req.wr)
                 |=> !(cfg_req.rd || cfg_req.wr) [*2])
    else $error("config transactions overlap");
  AST_PLL_ONLY: assert property ((st.fsm == S_LOCK && st.pll_only)
                  |-> !tx_side_reset && !rx_side_reset)
    else $error("pll-only sequence asserted other resets");

  // ****************************************************************
  // handshake and output relations
  // ****************************************************************
  // some of these hold by construction; they pin the contract down
  AST_STROBE_EXCL: assert property (!(cfg_req.rd && cfg_req.wr))
    else $error("config read and write strobes together");
  AST_STROBE_OWNED: assert property ((cfg_req.rd || cfg_req.wr)
                      |-> st.own != OWN_NONE && st.issued)
    else $error("config strobe without an owner");
  AST_READ_TUNER: assert property (cfg_req.rd |-> st.own == OWN_TUNE)
    else $error("config read issued by a reset sequencer");
  AST_RELEASE: assert property ((st.issued && cfg_rsp.ready)
                 |=> st.own == OWN_NONE && !st.issued)
    else $error("config port kept after ready");
  AST_BUSY_TUNE: assert property ((st.fsm inside {S_TWR, S_TRD}) |-> config_port_busy)
    else $error("busy low while tuning runs");
  AST_DONE_CLEAN: assert property (fsm_done |-> !tx_side_reset && !rx_side_reset)
    else $error("done while a side reset is asserted");
  AST_RECAL_PHASE: assert property (pll_recalibrate |-> st.fsm == S_PLL)
    else $error("recalibration outside the pll phase");
  AST_LANE_EN: assert property ((st.fsm != S_INIT)
                 |-> tx_serializer_enable == st.lane_en
                     && rx_deserializer_enable == st.lane_en)
    else $error("lane enables differ from the enable mask");
  AST_FAB_EQ: assert property (rx_fabric_if_reset == rx_side_reset)
    else $error("fabric interface reset differs from rx reset");
  AST_RX_ONLY_TX: assert property ((st.fsm == S_RST && st.rx_only)
                    |-> !tx_side_reset)
    else $error("tx reset during rx-only reset");
  AST_RETUNE_NO_RST: assert property ((st.fsm == S_DONE && st.user_req == 3'b001)
                       |=> !tx_side_reset && !rx_side_reset)
    else $error("retune repeated a reset");
  AST_INIT_RST: assert property ((st.fsm == S_INIT) |-> tx_side_reset && rx_side_reset)
    else $error("resets low in the initial state");

  COV_DONE: cover property ($rose(fsm_done));
  COV_POLL: cover property (st.fsm == S_TRD && xfer_done && !tune_all_done);
  COV_RETUNE: cover property (st.fsm == S_DONE ##1 st.fsm == S_TWR);
  COV_PLL_ONLY: cover property (st.pll_only ##[1:300] fsm_done);
  COV_AUX: cover property (st.own == OWN_FULL && st.issued && cfg_rsp.ready);

endmodule
`default_nettype wire

// *** hw/srct_map.svh ***
// register offsets, field positions, reset values and counts of the sequencer
// ****************************************************************************
// ****************************************************************************
`ifndef SRCT_MAP_SVH
`define SRCT_MAP_SVH
`define SRCT_OFF_CTRL      12'h000
`define SRCT_OFF_TUNE      12'h004
`define SRCT_OFF_ADDR      12'h008
`define SRCT_OFF_AUX       12'h00c
`define SRCT_OFF_STATUS    12'h010
`define SRCT_CTRL_RETUNE   0
`define SRCT_CTRL_RXRETUNE 1
`define SRCT_CTRL_PLLONLY  2
`define SRCT_CTRL_SEQ_LSB  3
`define SRCT_CTRL_LANE_LSB 8
`define SRCT_TUNE_MODE_LSB 8
`define SRCT_TUNE_EN_LSB   16
`define SRCT_LANE_EN_RST   8'hff
`define SRCT_HOLD_CYC      8'h10
`endif

// *** hw/srct_pkg.sv ***
// types of the serdes reset and equalizer tuning sequencer
package srct_pkg;
  typedef enum logic [2:0] {
    S_INIT  = 3'b000, S_PLL  = 3'b001, S_LOCK = 3'b010, S_RST  = 3'b011,
    S_RDONE = 3'b100, S_TWR  = 3'b101, S_TRD  = 3'b110, S_DONE = 3'b111
  } srct_state_t;
  typedef enum logic [2:0] {
    OWN_NONE = 3'b000, OWN_FULL = 3'b001, OWN_ANA = 3'b010,
    OWN_RATE = 3'b011, OWN_TUNE = 3'b100
  } srct_owner_t;
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [15:0] addr;
    logic [15:0] wdata;
  } srct_cfg_req_t;
  typedef struct packed {
    logic        ready;
    logic [15:0] rdata;
  } srct_cfg_rsp_t;
  typedef struct packed {
    logic [7:0] tx_en;
    logic [7:0] rx_en;
    logic       recal;
    logic       tx_rst;
    logic       rx_rst;
    logic       fab_rst;
    logic       done;
    logic       busy;
  } srct_lane_out_t;
  typedef struct packed {
    srct_state_t    fsm;
    srct_owner_t    own;
    logic           issued;
    logic [2:0]     pend;
    logic [7:0]     cnt;
    logic           rx_only;
    logic           pll_only;
    logic [2:0]     user_req;
    logic [7:0]     tune_mask;
    logic [7:0]     tuned;
    logic [7:0]     dis_mask;
    logic [7:0]     lane_en;
    logic [3:0]     mode;
    logic [2:0]     lane_sel;
    logic [15:0]    stat_addr;
    logic [15:0]    mode_addr;
    logic [15:0]    aux_addr;
    logic [15:0]    aux_data;
    logic [31:0]    prdata;
    srct_cfg_req_t  req;
    srct_lane_out_t out;
  } srct_st_t;
endpackage

// *** test/srct_octal_model.sv ***
// far-side model of the octal: config port answers, pll locks, reset-done lines
`timescale 1ns/1ps
`default_nettype none
module srct_octal_model
  import srct_pkg::*;
(
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire srct_cfg_req_t cfg_req,
  output var  srct_cfg_rsp_t cfg_rsp,
  input  wire logic          pll_recalibrate,
  input  wire logic          tx_side_reset,
  input  wire logic          rx_side_reset,
  input  wire logic          slow,
  input  wire logic [7:0]    tuned,
  output logic               tx_pll_locked,
  output logic               rx_pll_locked,
  output logic               tx_reset_complete,
  output logic               rx_reset_complete,
  output logic               proto_err
);
  logic       pend;
  logic       is_rd;
  logic [2:0] wait_cnt;
  logic       rd_seen;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend              <= 1'b0;
      is_rd             <= 1'b0;
      wait_cnt          <= 3'h0;
      rd_seen           <= 1'b0;
      cfg_rsp           <= '0;
      tx_pll_locked     <= 1'b0;
      rx_pll_locked     <= 1'b0;
      tx_reset_complete <= 1'b0;
      rx_reset_complete <= 1'b0;
      proto_err         <= 1'b0;
    end else begin
      // locks drop while the pll recalibrates
      tx_pll_locked     <= !pll_recalibrate;
      rx_pll_locked     <= !pll_recalibrate;
      tx_reset_complete <= !tx_side_reset;
      rx_reset_complete <= !rx_side_reset;
      cfg_rsp.ready     <= 1'b0;
      // idle read data toggles so stale values never look valid
      cfg_rsp.rdata     <= ~cfg_rsp.rdata;
      if ((cfg_req.rd || cfg_req.wr) && pend) begin
        proto_err <= 1'b1;
      end
      if (cfg_req.rd || cfg_req.wr) begin
        pend     <= 1'b1;
        is_rd    <= cfg_req.rd;
        wait_cnt <= slow ? 3'h4 : 3'h0;
      end else if (pend && wait_cnt != 3'h0) begin
        wait_cnt <= wait_cnt - 3'h1;
      end else if (pend) begin
        pend          <= 1'b0;
        cfg_rsp.ready <= 1'b1;
        // first poll after a mode write reports no lane finished yet
        rd_seen       <= is_rd;
        cfg_rsp.rdata <= is_rd ? (rd_seen ? {8'h00, tuned} : 16'h0000)
                               : ~cfg_rsp.rdata;
      end
    end
  end
endmodule
`default_nettype wire

// *** test/srct_seq_tb_top.sv ***
// self-checking bench of the reset and equalizer tuning sequencer
`timescale 1ns/1ps
`default_nettype none
`include "srct_map.svh"
module srct_seq_tb_top;
  import srct_pkg::*;
  logic          pclk = 1'b0;
  logic          presetn = 1'b0;
  logic          psel = 1'b0;
  logic          penable = 1'b0;
  logic          pwrite = 1'b0;
  logic [11:0]   paddr = 12'h000;
  logic [31:0]   pwdata = 32'h0;
  logic [31:0]   prdata;
  logic          pready, pslverr, tx_lk, rx_lk, tx_rc, rx_rc;
  srct_cfg_req_t cfg_req;
  srct_cfg_rsp_t cfg_rsp;
  logic [7:0]    tx_en, rx_en;
  logic          recal, tx_rst, rx_rst, fab_rst, done, busy, proto_err;
  logic          slow = 1'b0;
  logic [7:0]    tuned = 8'h00;
  int            n_fail = 0;
  int            samples_checked = 0;
  logic [31:0]   rng = 32'h42625294;
  always #12.5 pclk = ~pclk;
  srct_seq uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .tx_reset_complete(tx_rc), .rx_reset_complete(rx_rc),
    .tx_pll_locked(tx_lk), .rx_pll_locked(rx_lk), .cfg_rsp(cfg_rsp), .cfg_req(cfg_req),
    .tx_serializer_enable(tx_en), .rx_deserializer_enable(rx_en), .pll_recalibrate(recal),
    .tx_side_reset(tx_rst), .rx_side_reset(rx_rst), .rx_fabric_if_reset(fab_rst),
    .fsm_done(done), .config_port_busy(busy));
  srct_octal_model octal (.pclk(pclk), .presetn(presetn), .cfg_req(cfg_req),
    .cfg_rsp(cfg_rsp), .pll_recalibrate(recal), .tx_side_reset(tx_rst),
    .rx_side_reset(rx_rst), .slow(slow), .tuned(tuned), .tx_pll_locked(tx_lk),
    .rx_pll_locked(rx_lk), .tx_reset_complete(tx_rc), .rx_reset_complete(rx_rc),
    .proto_err(proto_err));
  function automatic logic [31:0] xrnd();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction
  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    chk_word({31'h0, got}, {31'h0, exp});
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    e = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task automatic wreg(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask
  // bounded wait for one config strobe, then address, write data (writes only) and busy checks
  task automatic wait_strobe(input logic rd, input logic [15:0] a, input logic [15:0] d);
    int n;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while ((rd ? cfg_req.rd : cfg_req.wr) !== 1'b1 && n < 3000);
    chk_bit(rd ? cfg_req.rd : cfg_req.wr, 1'b1);
    chk_word({16'h0, cfg_req.addr}, {16'h0, a});
    if (!rd) chk_word({16'h0, cfg_req.wdata}, {16'h0, d});
    chk_bit(busy, 1'b1);
  endtask
  // done falls, then rises again; records writes and the reset lines seen
  task automatic wait_done(output int nwr, output logic [15:0] wd, output logic [2:0] saw);
    int n;
    nwr = 0;
    saw = 3'h0;
    wd = 16'h0;
    for (n = 0; n < 10 && done !== 1'b0; n++) @(posedge pclk);
    for (n = 0; n < 3000 && done !== 1'b1; n++) begin
      @(posedge pclk);
      if (cfg_req.wr === 1'b1) begin
        nwr++;
        wd = cfg_req.wdata;
      end
      saw = saw | {tx_rst, rx_rst, recal};
    end
    chk_bit(done, 1'b1);
  endtask
  always @(posedge pclk) begin
    if (presetn === 1'b1 && done === 1'b1) chk_bit(tx_rst | rx_rst, 1'b0);
    if (presetn === 1'b1 && recal === 1'b1) chk_bit(|{tx_en, rx_en}, 1'b1);
  end
  initial begin
    #(25 * 40000);
    n_fail++;
    test_done();
  end
  initial begin
    logic [31:0] r;
    logic        e;
    logic [15:0] sa, ma, wd, ab, ad;
    logic [7:0]  dis;
    logic [3:0]  md;
    logic [2:0]  ln, saw;
    int          nwr;
    repeat (10) @(posedge pclk);
    chk_word({16'h0, tx_en, rx_en}, 32'h0);
    chk_word({27'h0, tx_rst, rx_rst, fab_rst, done, busy}, 32'h1c);
    presetn <= 1'b1;
    {sa, ma} = xrnd();
    dis = 8'(xrnd()) & 8'h7f;
    md = 4'(xrnd());
    wreg(`SRCT_OFF_ADDR, {ma, sa});
    wreg(`SRCT_OFF_TUNE, {8'h0, 8'hff, 4'h0, md, dis});
    wait_strobe(1'b0, ma, {4'h0, md, ~dis});
    wait_strobe(1'b1, sa, 16'h0);
    tuned <= 8'hff;
    wait_strobe(1'b1, sa, 16'h0);
    chk_bit(done, 1'b0);
    wait_done(nwr, wd, saw);
    chk_word({16'h0, tx_en, rx_en}, 32'hffff);
    chk_bit(fab_rst, 1'b0);
    $display("test init finished");
    wreg(`SRCT_OFF_CTRL, 32'h2);
    wait_done(nwr, wd, saw);
    chk_word({30'h0, saw[2:1]}, 32'h1);
    chk_word({16'h0, wd}, {20'h0, md, ~dis});
    $display("test rx reset retune finished");
    md = 4'(xrnd());
    wreg(`SRCT_OFF_TUNE, {8'h0, 8'hff, 4'h0, md, 8'hff});
    wreg(`SRCT_OFF_CTRL, 32'h1);
    wait_done(nwr, wd, saw);
    chk_word(nwr, 32'h0);
    wreg(`SRCT_OFF_TUNE, {8'h0, 8'hff, 4'h0, md, 8'h00});
    repeat (3) begin
      ln = 3'(xrnd());
      slow <= 1'(xrnd());
      wreg(`SRCT_OFF_CTRL, {21'h0, ln, 8'h00});
      wreg(`SRCT_OFF_CTRL, {21'h0, ln, 8'h01});
      wait_done(nwr, wd, saw);
      chk_word({29'h0, saw[2:1], 1'b0}, 32'h0);
      chk_word({16'h0, wd}, {20'h0, md, 8'h01 << ln});
    end
    $display("test lane retune finished");
    wreg(`SRCT_OFF_CTRL, 32'h4);
    wait_done(nwr, wd, saw);
    chk_word({nwr[28:0], saw}, 32'h1);
    $display("test pll only finished");
    ad = 16'(xrnd() >> 16);
    ab = 16'h0100;
    wreg(`SRCT_OFF_AUX, {ad, ab});
    wreg(`SRCT_OFF_CTRL, 32'h38);
    wait_strobe(1'b0, ab + 16'h1, ad);
    wait_strobe(1'b0, ab + 16'h2, ad);
    wait_strobe(1'b0, ab + 16'h3, ad);
    repeat (20) @(posedge pclk);
    apb(1'b0, `SRCT_OFF_STATUS, 32'h0, r, e);
    chk_word(r & 32'h00ff_00ff, {8'h0, 8'h01 << ln, 8'h0, OWN_NONE, S_DONE, 2'b01});
    chk_bit(proto_err, 1'b0);
    $display("test arbitration finished");
    apb(1'b1, 12'h024, 32'hffffffff, r, e);
    apb(1'b0, 12'h024, 32'h0, r, e);
    chk_word({r[31:1], e}, 32'h1);
    apb(1'b0, `SRCT_OFF_TUNE, 32'h0, r, e);
    chk_word(r, {8'h0, 8'hff, 4'h0, md, 8'h00});
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    chk_word({14'h0, tx_en, rx_en, done, busy}, 32'h0);
    $display("test register and reset finished");
    test_done();
  end
endmodule
`default_nettype wire
